// [inc/atf_pkg.sv]
`default_nettype none
package atf_pkg;
	// ---------------------------------------------------------------
	// Instruction codes
	// ---------------------------------------------------------------
	localparam logic [7:0] ATF_OP_ACCU_TO_AXIS = 8'h22;
	localparam logic [7:0] ATF_OP_ACCU_TO_GLOBAL = 8'h23;
	localparam logic [7:0] ATF_OP_CLEAR_FLAGS = 8'h24;
	localparam logic [7:0] ATF_OP_UNMASK_IRQ = 8'h19;
	localparam logic [7:0] ATF_OP_MASK_IRQ = 8'h1A;
	// ---------------------------------------------------------------
	// Field values
	// ---------------------------------------------------------------
	localparam logic [7:0] ATF_IRQ_GLOBAL = 8'hFF;
	localparam logic [7:0] ATF_BANK_0 = 8'h00;
	localparam logic [7:0] ATF_BANK_USER = 8'h02;
	localparam logic [7:0] ATF_BANK_3 = 8'h03;
	localparam logic [7:0] ATF_MOTOR_0 = 8'h00;
	localparam logic [7:0] ATF_FLAG_ALL = 8'h00;
	localparam logic [7:0] ATF_FLAG_LAST = 8'h05;
	localparam int ATF_NUM_FLAGS = 5;
	localparam logic [7:0] ATF_STATUS_OK = 8'h64;
	localparam logic [7:0] ATF_STATUS_BAD_SUM = 8'h01;
	localparam logic [7:0] ATF_STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0] ATF_STATUS_BAD_VAL = 8'h04;
	localparam logic [3:0] ATF_FRAME_LAST = 4'h8;
	localparam int ATF_IRQ_NUM = 32;
	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	// Parameter write toward the parameter store
	typedef struct packed {
		logic axis;
		logic [7:0] bank;
		logic [7:0] index;
		logic [31:0] data;
	} atf_pwrite_type;
	// Reply toward the host side
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] opcode;
		logic [31:0] value;
	} atf_reply_type;
	typedef enum logic [1:0] {ATF_IDLE, ATF_EXEC, ATF_REPLY} atf_state_type;
endpackage : atf_pkg
`default_nettype wire

// [sim/atf_cmd_chk.sv]
`default_nettype none
module atf_cmd_chk
	import atf_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [31:0] i_accu,
	input wire logic [ATF_NUM_FLAGS-1:0] i_error_set,
	input wire logic o_busy,
	input wire logic o_reply_valid,
	input wire atf_reply_type o_reply,
	input wire logic o_pwrite_valid,
	input wire atf_pwrite_type o_pwrite,
	input wire logic [ATF_NUM_FLAGS-1:0] o_error_flags,
	input wire logic [ATF_IRQ_NUM-1:0] o_irq_enable,
	input wire logic o_irq_global
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Properties
	// ----
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// Execution cycle then reply
	sequence s_exec_reply;
		o_busy ##1 o_reply_valid;
	endsequence
	AST_REPLY_VALUE: assert property (s_exec_reply |-> o_reply.value == 32'h0)
		else $error("reply value not zero");
	AST_REPLY_AFTER_EXEC: assert property (o_reply_valid |-> $past(o_busy))
		else $error("reply without execution");
	AST_PW_ACCU: assert property (o_pwrite_valid |-> o_pwrite.data == $past(i_accu))
		else $error("write data not accumulator");
	AST_PW_PULSE: assert property (o_pwrite_valid |=> !o_pwrite_valid)
		else $error("write strobe too long");
	AST_AXIS_MOTOR: assert property (o_pwrite_valid && o_pwrite.axis
		|-> o_pwrite.bank == 8'h00)
		else $error("axis write to bad motor");
	AST_GLOBAL_BANK: assert property (o_pwrite_valid && !o_pwrite.axis
		|-> o_pwrite.bank inside {8'h00, 8'h02, 8'h03})
		else $error("global write to bad bank");
	AST_FLAG_SET: assert property (i_ce && i_error_set != '0
		|=> (o_error_flags & $past(i_error_set)) == $past(i_error_set))
		else $error("error event lost");
	AST_FLAG_HOLD: assert property (!$past(o_busy)
		|-> (o_error_flags & $past(o_error_flags)) == $past(o_error_flags))
		else $error("flag cleared without command");
	AST_IRQ_HOLD: assert property (!$past(o_busy)
		|-> $stable(o_irq_enable) && $stable(o_irq_global))
		else $error("interrupt enable changed alone");
endmodule : atf_cmd_chk
bind atf_cmd atf_cmd_chk atf_cmd_chk_inst (.i_core_clk, .i_rst_n, .i_ce, .i_accu, .i_error_set,
	.o_busy, .o_reply_valid, .o_reply, .o_pwrite_valid, .o_pwrite, .o_error_flags,
	.o_irq_enable, .o_irq_global);
`default_nettype wire

// [sim/atf_cmd_tb.sv]
`default_nettype none
module atf_cmd_tb
	import atf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 0, i_rst_n = 0, i_frame_start = 0, i_prog_valid = 0, i_ce = 1;
	logic [7:0] i_prog_opcode = 8'h00, i_prog_type = 8'h00, i_prog_bank = 8'h00;
	logic [31:0] i_accu = 32'h0, o_irq_enable;
	logic [4:0] i_error_set = 5'h00, o_error_flags;
	logic i_byte_valid, o_busy, o_reply_valid, o_pwrite_valid, o_irq_global;
	logic [7:0] i_byte;
	atf_reply_type o_reply;
	atf_pwrite_type o_pwrite, pw;
	int fails = 0, checked = 0;
	atf_cmd atf_cmd_inst (.i_core_clk, .i_rst_n, .i_ce, .i_byte_valid, .i_byte,
		.i_frame_start, .i_prog_valid, .i_prog_opcode, .i_prog_type, .i_prog_bank, .i_accu,
		.i_error_set, .o_busy, .o_reply_valid, .o_reply, .o_pwrite_valid, .o_pwrite,
		.o_error_flags, .o_irq_enable, .o_irq_global);
	atf_host atf_host_inst (.i_clk(i_core_clk), .o_byte_valid(i_byte_valid), .o_byte(i_byte));
	// ----
	// Tasks
	// ----
	initial forever #2 i_core_clk = ~i_core_clk;
	task end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	task chk(input logic [48:0] s, input logic [48:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// Send a frame, wait a bounded time for the reply, check its status
	task run(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk, input logic bad,
		input logic [7:0] st);
		int n;
		atf_host_inst.send(op, ty, bk, bad);
		n = 0;
		while (o_reply_valid !== 1'b1 && n < 8) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n == 8) begin
			$display("BAD %0t no reply", $time);
			fails++;
			end_of_test();
		end else begin
			pw = o_pwrite_valid ? o_pwrite : '0;
			chk(o_reply.status, st);
			chk({o_busy, o_reply.opcode, o_reply.value}, {1'b1, op, 32'h0});
			chk(n, 1);
			$display("test %h %h %h done", op, ty, bk);
		end
	endtask : run
	// ----
	// Sequence
	// ----
	initial begin
		repeat (6) @(negedge i_core_clk);
		i_rst_n = 1;
		i_frame_start = 1;
		@(negedge i_core_clk);
		i_frame_start = 0;
		i_accu = 32'hCAFE0123;
		run(ATF_OP_ACCU_TO_AXIS, 8'h04, ATF_MOTOR_0, 0, ATF_STATUS_OK);
		chk(pw, {1'b1, ATF_MOTOR_0, 8'h04, 32'hCAFE0123});
		i_accu = 32'h000000A5;
		run(ATF_OP_ACCU_TO_GLOBAL, 8'h2A, ATF_BANK_USER, 0, ATF_STATUS_OK);
		chk(pw, {1'b0, ATF_BANK_USER, 8'h2A, 32'hA5});
		run(ATF_OP_ACCU_TO_GLOBAL, 8'h01, ATF_BANK_3, 0, ATF_STATUS_OK);
		chk(pw, {1'b0, ATF_BANK_3, 8'h01, 32'hA5});
		run(ATF_OP_ACCU_TO_GLOBAL, 8'h01, 8'h01, 0, ATF_STATUS_BAD_VAL);
		chk(pw, '0);
		run(ATF_OP_ACCU_TO_AXIS, 8'h00, 8'h01, 0, ATF_STATUS_BAD_VAL);
		chk(pw, '0);
		run(ATF_OP_ACCU_TO_AXIS, 8'h00, ATF_MOTOR_0, 1, ATF_STATUS_BAD_SUM);
		chk(pw, '0);
		run(ATF_OP_UNMASK_IRQ, 8'h05, 8'h07, 0, ATF_STATUS_OK);
		chk(o_irq_enable, 32'h20);
		run(ATF_OP_UNMASK_IRQ, ATF_IRQ_GLOBAL, 8'h07, 0, ATF_STATUS_OK);
		chk({o_irq_global, o_irq_enable}, 33'h100000020);
		run(ATF_OP_MASK_IRQ, 8'h05, 8'h07, 0, ATF_STATUS_OK);
		chk({o_irq_global, o_irq_enable}, 33'h100000000);
		run(ATF_OP_MASK_IRQ, ATF_IRQ_GLOBAL, 8'h07, 0, ATF_STATUS_OK);
		chk(o_irq_global, 1'b0);
		// Out-of-range interrupt and unknown opcode are refused
		run(ATF_OP_UNMASK_IRQ, 8'h20, 8'h00, 0, ATF_STATUS_BAD_VAL);
		run(8'h21, 8'h00, 8'h00, 0, ATF_STATUS_BAD_CMD);
		// Each single-flag code, then clear-all
		for (int k = 1; k <= 6; k++) begin
			i_error_set = 5'h1F;
			@(negedge i_core_clk);
			i_error_set = 5'h00;
			run(ATF_OP_CLEAR_FLAGS, 8'(k % 6), 8'h09, 0, ATF_STATUS_OK);
			chk(o_error_flags, (k == 6) ? 5'h00 : 5'h1F & ~(5'h01 << (k - 1)));
		end
		run(ATF_OP_CLEAR_FLAGS, 8'h06, 8'h00, 0, ATF_STATUS_BAD_VAL);
		// Standalone program issues an enable, once the reply cycle has drained
		@(negedge i_core_clk);
		i_prog_opcode = ATF_OP_UNMASK_IRQ;
		i_prog_type = 8'h07;
		i_prog_valid = 1;
		@(negedge i_core_clk);
		i_prog_valid = 0;
		repeat (2) @(negedge i_core_clk);
		chk(o_irq_enable, 32'h80);
		$display("test program port done");
		// Clock enable low: a program disable must not touch the enables
		i_ce = 0;
		i_prog_opcode = ATF_OP_MASK_IRQ;
		i_prog_valid = 1;
		@(negedge i_core_clk);
		i_prog_valid = 0;
		repeat (2) @(negedge i_core_clk);
		chk(o_irq_enable, 32'h80);
		i_ce = 1;
		repeat (2) @(negedge i_core_clk);
		chk(o_irq_enable, 32'h80);
		$display("test clock enable done");
		end_of_test();
	end
endmodule : atf_cmd_tb
`default_nettype wire

// [sim/atf_host.sv]
`default_nettype none
module atf_host
(
	input wire logic i_clk,
	output logic o_byte_valid,
	output logic [7:0] o_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Frame sender
	// ----
	initial begin
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
	end
	// One frame, back to back, checksum optionally broken
	task send(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] bk, input logic bad);
		logic [7:0] f [9];
		f = '{8'h01, op, ty, bk, 8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h00};
		for (int i = 0; i < 8; i++) begin
			f[8] += f[i];
		end
		f[8] ^= {7'h00, bad};
		for (int i = 0; i < 9; i++) begin
			@(negedge i_clk);
			o_byte_valid = 1'b1;
			o_byte = f[i];
		end
		@(negedge i_clk);
		o_byte_valid = 1'b0;
		o_byte = ~o_byte; // Released: no stale byte
	endtask : send
endmodule : atf_host
`default_nettype wire

// [src/atf_cmd.sv]
// How it works
// - Code 34 is accu-to-axis-parameter, type is the parameter, motor/bank the motor (only 0).
// - On code 34 the accumulator is written to the selected axis parameter of the motor.
// - Code 35 writes the accumulator to global parameter type in bank 0, 2 or 3.
// - Bank 2 holds user variables, so code 35 to bank 2 stores the accumulator there.
// - Code 36 clears error flags picked by type, ignoring motor/bank and value.
// - Flag type 0 clears all, 1 timeout, 2 alarm, 3 deviation, 4 position, 5 shutdown.
// - Code 25 enables the interrupt numbered by type, ignoring motor/bank and value.
// - Code 25 with number 255 turns global interrupt processing on.
// - Code 26 disables the interrupt numbered by type, ignoring motor/bank and value.
// - Code 26 with number 255 turns global interrupt processing off.
// - Each host frame is answered with status 100 when legal, else 1, 2 or 4; program-port commands get no reply. The reply value carries nothing.
`default_nettype none
module atf_cmd
	import atf_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_frame_start,
	input wire logic i_prog_valid,
	input wire logic [7:0] i_prog_opcode,
	input wire logic [7:0] i_prog_type,
	input wire logic [7:0] i_prog_bank,
	input wire logic [31:0] i_accu,
	input wire logic [ATF_NUM_FLAGS-1:0] i_error_set,
	output logic o_busy,
	output logic o_reply_valid,
	output atf_reply_type o_reply,
	output logic o_pwrite_valid,
	output atf_pwrite_type o_pwrite,
	output logic [ATF_NUM_FLAGS-1:0] o_error_flags,
	output logic [ATF_IRQ_NUM-1:0] o_irq_enable,
	output logic o_irq_global
);
	// ---------------------------------------------------------------
	// Frame assembly
	// ---------------------------------------------------------------
	logic [3:0] byte_cnt;
	logic [7:0] sum;
	logic [7:0] f_opcode;
	logic [7:0] f_type;
	logic [7:0] f_bank;
	logic frame_done;
	logic frame_ok;
	atf_state_type state;
	logic from_host;
	logic [7:0] c_opcode;
	logic [7:0] c_type;
	logic [7:0] c_bank;
	logic [7:0] status;
	logic exec_ok;

	// Decides whether a type/bank pair is legal for an opcode
	function automatic logic [7:0] atf_check(input logic [7:0] op, input logic [7:0] typ,
		input logic [7:0] bnk);
		logic [7:0] res;
		res = ATF_STATUS_OK;
		case (op)
			ATF_OP_ACCU_TO_AXIS: if (bnk != ATF_MOTOR_0) res = ATF_STATUS_BAD_VAL;
			ATF_OP_ACCU_TO_GLOBAL: begin
				if (bnk != ATF_BANK_0 && bnk != ATF_BANK_USER && bnk != ATF_BANK_3) begin
					res = ATF_STATUS_BAD_VAL;
				end
			end
			ATF_OP_CLEAR_FLAGS: if (typ > ATF_FLAG_LAST) res = ATF_STATUS_BAD_VAL;
			ATF_OP_UNMASK_IRQ, ATF_OP_MASK_IRQ: begin
				if (typ != ATF_IRQ_GLOBAL && typ >= 8'(ATF_IRQ_NUM)) res = ATF_STATUS_BAD_VAL;
			end
			default: res = ATF_STATUS_BAD_CMD;
		endcase
		return res;
	endfunction : atf_check

	// Nine bytes, address first and checksum last; value bytes are don't care here
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			byte_cnt <= 4'h0;
			sum <= 8'h00;
			f_opcode <= 8'h00;
			f_type <= 8'h00;
			f_bank <= 8'h00;
		end else if (i_ce) begin
			if (i_frame_start) begin
				byte_cnt <= 4'h0;
				sum <= 8'h00;
			end else if (i_byte_valid && state == ATF_IDLE) begin
				byte_cnt <= (byte_cnt == ATF_FRAME_LAST) ? 4'h0 : byte_cnt + 4'h1;
				sum <= (byte_cnt == ATF_FRAME_LAST) ? 8'h00 : sum + i_byte;
				if (byte_cnt == 4'h1) f_opcode <= i_byte;
				if (byte_cnt == 4'h2) f_type <= i_byte;
				if (byte_cnt == 4'h3) f_bank <= i_byte;
			end
		end
	end

	assign frame_done = i_byte_valid && !i_frame_start && state == ATF_IDLE
		&& byte_cnt == ATF_FRAME_LAST;
	assign frame_ok = (i_byte == sum);
	assign o_busy = (state != ATF_IDLE);

	// ---------------------------------------------------------------
	// Command sequencer
	// ---------------------------------------------------------------
	// Host frames win over the program port when both arrive together
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ATF_IDLE;
			from_host <= 1'b0;
			c_opcode <= 8'h00;
			c_type <= 8'h00;
			c_bank <= 8'h00;
			status <= ATF_STATUS_OK;
		end else if (i_ce) begin
			case (state)
				ATF_IDLE: begin
					if (frame_done) begin
						from_host <= 1'b1;
						c_opcode <= f_opcode;
						c_type <= f_type;
						c_bank <= f_bank;
						status <= frame_ok ? atf_check(f_opcode, f_type, f_bank)
							: ATF_STATUS_BAD_SUM;
						state <= ATF_EXEC;
					end else if (i_prog_valid) begin
						from_host <= 1'b0;
						c_opcode <= i_prog_opcode;
						c_type <= i_prog_type;
						c_bank <= i_prog_bank;
						status <= atf_check(i_prog_opcode, i_prog_type, i_prog_bank);
						state <= ATF_EXEC;
					end
				end
				ATF_EXEC: state <= from_host ? ATF_REPLY : ATF_IDLE;
				ATF_REPLY: state <= ATF_IDLE;
				default: state <= ATF_IDLE;
			endcase
		end
	end

	assign exec_ok = (state == ATF_EXEC) && (status == ATF_STATUS_OK);

	// ---------------------------------------------------------------
	// Parameter write
	// ---------------------------------------------------------------
	// Accumulator sampled in the execute cycle, so the caller loads it first
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pwrite_valid <= 1'b0;
			o_pwrite <= '0;
		end else if (i_ce) begin
			o_pwrite_valid <= 1'b0;
			if (exec_ok && c_opcode == ATF_OP_ACCU_TO_AXIS) begin
				o_pwrite_valid <= 1'b1;
				o_pwrite <= '{axis: 1'b1, bank: c_bank, index: c_type, data: i_accu};
			end else if (exec_ok && c_opcode == ATF_OP_ACCU_TO_GLOBAL) begin
				o_pwrite_valid <= 1'b1;
				o_pwrite <= '{axis: 1'b0, bank: c_bank, index: c_type, data: i_accu};
			end
		end
	end

	// ---------------------------------------------------------------
	// Error flags
	// ---------------------------------------------------------------
	// A new error in the clearing cycle wins, so no event is lost
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_error_flags <= '0;
		end else if (i_ce) begin
			for (int i = 0; i < ATF_NUM_FLAGS; i++) begin
				if (i_error_set[i]) begin
					o_error_flags[i] <= 1'b1;
				end else if (exec_ok && c_opcode == ATF_OP_CLEAR_FLAGS
					&& (c_type == ATF_FLAG_ALL || c_type == 8'(i + 1))) begin
					o_error_flags[i] <= 1'b0;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt enables
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq_enable <= '0;
			o_irq_global <= 1'b0;
		end else if (i_ce && exec_ok) begin
			if (c_opcode == ATF_OP_UNMASK_IRQ) begin
				if (c_type == ATF_IRQ_GLOBAL) o_irq_global <= 1'b1;
				else o_irq_enable[c_type[4:0]] <= 1'b1;
			end else if (c_opcode == ATF_OP_MASK_IRQ) begin
				if (c_type == ATF_IRQ_GLOBAL) o_irq_global <= 1'b0;
				else o_irq_enable[c_type[4:0]] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Reply
	// ---------------------------------------------------------------
	// Value field carries nothing useful, so it is held at zero
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reply_valid <= 1'b0;
			o_reply <= '0;
		end else if (i_ce) begin
			o_reply_valid <= 1'b0;
			if (state == ATF_EXEC && from_host) begin
				o_reply_valid <= 1'b1;
				o_reply <= '{status: status, opcode: c_opcode, value: 32'h0000_0000};
			end
		end
	end
endmodule : atf_cmd
`default_nettype wire
